// *** pkg/das_pkg.sv ***
// Constants shared by the drive auxiliary supervisor
package das_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned FAN_PRERUN_S = 60;
  localparam longint unsigned FAN_PRERUN_CYC = longint'(FAN_PRERUN_S) * CLK_HZ;
  // Rapid stop ramp: 0.01 s units, 0.00..650.00 s, default 1.00
  localparam logic [15:0] RSTOP_MAX = 16'hFDE8;
  localparam logic [15:0] RSTOP_DEF = 16'h0064;

  // ---------------------------------------------------------------
  // Register map (byte address, word index = address / 4)
  // ---------------------------------------------------------------
  localparam logic [7:0] A_BRAKE_CTRL = 8'h00;  // [0] enable, [14:8] duty rate
  localparam logic [7:0] A_BRAKE_VOLT = 8'h04;  // Threshold, 0.1 % units
  localparam logic [7:0] A_FREQ_CTRL = 8'h08;  // [0] below-limit action
  localparam logic [7:0] A_LOW_FREQ = 8'h0C;  // Lower limit, 0.01 Hz
  localparam logic [7:0] A_FAN_CTRL = 8'h10;  // Three decimal digits
  localparam logic [7:0] A_OVERMOD = 8'h14;  // 0.01 units
  localparam logic [7:0] A_MOD_CTRL = 8'h18;  // [0] switch opt, [5:4] dead zone
  localparam logic [7:0] A_MOD_FREQ = 8'h1C;  // 0.01 Hz
  localparam logic [7:0] A_JOG_CTRL = 8'h20;  // [0] jog priority, [2:1] cmd source
  localparam logic [7:0] A_RSTOP = 8'h24;  // 0.01 s
  localparam logic [7:0] A_CUR_THR = 8'h28;  // [15:0] thr, [31:16] hyst, 0.1 %
  localparam logic [7:0] A_TRQ_THR = 8'h2C;  // [15:0] thr, [31:16] hyst, 0.1 %
  localparam logic [7:0] A_STATUS = 8'h30;  // Read only

  // ---------------------------------------------------------------
  // Reset values and limits
  // ---------------------------------------------------------------
  localparam logic [6:0] DUTY_MIN = 7'h14;  // 20 %
  localparam logic [6:0] DUTY_MAX = 7'h64;  // 100 %
  localparam logic [15:0] BVOLT_DEF = 16'h04E2;  // 125.0 %
  localparam logic [9:0] FAN_DEF = 10'h101;  // Digits 1, 0, 1 as BCD nibbles
  localparam logic [6:0] OVM_MIN = 7'h64;  // 1.00
  localparam logic [6:0] OVM_MAX = 7'h6E;  // 1.10
  localparam logic [6:0] OVM_DEF = 7'h69;  // 1.05
  localparam logic [15:0] MODF_DEF = 16'h05DC;  // 15.00 Hz
  localparam logic [15:0] PCT_MAX = 16'h0BB8;  // 300.0 %
  localparam logic [15:0] THR_DEF = 16'h03E8;  // 100.0 %
  localparam logic [15:0] HYST_DEF = 16'h0032;  // 5.0 %
  localparam logic [1:0] DZ_DEF = 2'h1;
  localparam logic [1:0] SRC_TERMINAL = 2'h1;
  // Fan temperature band, 0.1 degC units
  localparam logic [15:0] FAN_ON_T = 16'h01C2;  // 45.0
  localparam logic [15:0] FAN_OFF_T = 16'h0190;  // 40.0

  // ---------------------------------------------------------------
  // Fan enumerations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FAN_POWER = 2'h0,
    FAN_START = 2'h1,
    FAN_TEMP = 2'h2
  } das_fan_mode_t;
  typedef enum logic [1:0] {
    FS_PRERUN = 2'h0,
    FS_MODE = 2'h1
  } das_fan_state_t;
endpackage

// *** verilog/das_top.sv ***
// Drive auxiliary supervisor: braking, fan, modulation, jog and reach flags
module das_top
  import das_pkg::*;
#(
  parameter longint unsigned PRERUN_CYC = FAN_PRERUN_CYC,
  parameter int unsigned PWM_STEPS = 100
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Measurements, 0.1 % / 0.1 degC / 0.01 Hz units
  input wire logic [15:0] bus_volt_i,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] out_cur_i,
  input wire logic [15:0] out_trq_i,
  input wire logic [15:0] out_freq_i,
  input wire logic [15:0] set_freq_i,
  // Drive status
  input wire logic running_i,
  input wire logic jog_term_i,
  // Outputs to power stage, fan and terminals
  output logic brake_sw_o,
  output logic fan_on_o,
  output logic fan_low_speed_o,
  output logic shutdown_o,
  output logic [15:0] freq_cmd_o,
  output logic five_seg_o,
  output logic [1:0] dead_zone_o,
  output logic [6:0] overmod_o,
  output logic jog_select_o,
  output logic [15:0] ramp_time_o,
  output logic cur_reached_o,
  output logic trq_reached_o
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (PWM_STEPS != 100) begin : g_chk_steps
    $error("PWM_STEPS must be 100 so the rate maps to percent");
  end
  if (PRERUN_CYC < 1) begin : g_chk_pre
    $error("PRERUN_CYC must be at least one cycle");
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_s1_q;
  logic rst_n_q;

  // Async assert, two-stage synchronous release
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Parameter registers
  // ---------------------------------------------------------------
  logic brake_en_q;
  logic [6:0] duty_q;
  logic [15:0] bvolt_q;
  logic below_act_q;
  logic [15:0] low_freq_q;
  logic [9:0] fan_set_q;
  logic [6:0] ovm_q;
  logic mod_sw_q;
  logic [1:0] dz_q;
  logic [15:0] mod_freq_q;
  logic jog_pri_q;
  logic [1:0] cmd_src_q;
  logic [15:0] rstop_q;
  logic [15:0] cur_thr_q;
  logic [15:0] cur_hys_q;
  logic [15:0] trq_thr_q;
  logic [15:0] trq_hys_q;

  // Write decode; out-of-range values are refused, register keeps its value
  wire wr_brk = wr_i && addr_i == A_BRAKE_CTRL;
  wire [6:0] w_duty = wdata_i[14:8];
  wire duty_ok = w_duty >= DUTY_MIN && w_duty <= DUTY_MAX;
  wire [6:0] w_ovm = wdata_i[6:0];
  wire ovm_ok = w_ovm >= OVM_MIN && w_ovm <= OVM_MAX;
  wire [3:0] w_d0 = wdata_i[3:0];
  wire [3:0] w_d1 = wdata_i[7:4];
  wire [3:0] w_d2 = wdata_i[11:8];
  // fan digits as BCD, each digit in range
  wire fan_ok = w_d0 <= 4'h2 && w_d1 <= 4'h1 && w_d2 >= 4'h1 && w_d2 <= 4'h2;
  wire dz_ok = wdata_i[5:4] != 2'h3;
  wire rstop_ok = wdata_i[15:0] <= RSTOP_MAX;
  // threshold range checks, hysteresis bounded by threshold
  wire cur_ok = wdata_i[15:0] <= PCT_MAX && wdata_i[31:16] <= wdata_i[15:0];
  wire trq_ok = cur_ok;

  // Configuration storage
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      brake_en_q <= 1'b0;
      duty_q <= DUTY_MAX;
      bvolt_q <= BVOLT_DEF;
      below_act_q <= 1'b0;
      low_freq_q <= 16'h0000;
      fan_set_q <= FAN_DEF;
      ovm_q <= OVM_DEF;
      mod_sw_q <= 1'b0;
      dz_q <= DZ_DEF;
      mod_freq_q <= MODF_DEF;
      jog_pri_q <= 1'b0;
      cmd_src_q <= 2'h0;
      rstop_q <= RSTOP_DEF;
      cur_thr_q <= THR_DEF;
      cur_hys_q <= HYST_DEF;
      trq_thr_q <= THR_DEF;
      trq_hys_q <= HYST_DEF;
    end else if (wr_i) begin
      if (wr_brk) begin
        brake_en_q <= wdata_i[0];
        if (duty_ok) begin
          duty_q <= w_duty;
        end
      end
      if (addr_i == A_BRAKE_VOLT) begin
        bvolt_q <= wdata_i[15:0];
      end
      if (addr_i == A_FREQ_CTRL) begin
        below_act_q <= wdata_i[0];
      end
      if (addr_i == A_LOW_FREQ) begin
        low_freq_q <= wdata_i[15:0];
      end
      if (addr_i == A_FAN_CTRL && fan_ok) begin
        fan_set_q <= wdata_i[9:0];
      end
      if (addr_i == A_OVERMOD && ovm_ok) begin
        ovm_q <= w_ovm;
      end
      if (addr_i == A_MOD_CTRL) begin
        mod_sw_q <= wdata_i[0];
        if (dz_ok) begin
          dz_q <= wdata_i[5:4];
        end
      end
      if (addr_i == A_MOD_FREQ) begin
        mod_freq_q <= wdata_i[15:0];
      end
      if (addr_i == A_JOG_CTRL) begin
        jog_pri_q <= wdata_i[0];
        cmd_src_q <= wdata_i[2:1];
      end
      if (addr_i == A_RSTOP && rstop_ok) begin
        rstop_q <= wdata_i[15:0];
      end
      if (addr_i == A_CUR_THR && cur_ok) begin
        cur_thr_q <= wdata_i[15:0];
        cur_hys_q <= wdata_i[31:16];
      end
      if (addr_i == A_TRQ_THR && trq_ok) begin
        trq_thr_q <= wdata_i[15:0];
        trq_hys_q <= wdata_i[31:16];
      end
    end
  end

  // ---------------------------------------------------------------
  // Dynamic braking
  // ---------------------------------------------------------------
  logic braking_q;
  logic [6:0] pwm_cnt_q;
  logic brake_sw_q;

  wire brk_start = brake_en_q && bus_volt_i > bvolt_q;
  // stop below threshold; equal keeps the present state
  wire brk_stop = !brake_en_q || bus_volt_i < bvolt_q;
  wire braking_d = brk_start ? 1'b1 : (brk_stop ? 1'b0 : braking_q);
  wire [6:0] pwm_next = pwm_cnt_q == 7'(PWM_STEPS - 1) ? 7'h00 : pwm_cnt_q + 7'h01;
  // duty equals rate; rate 100 keeps switch on all period
  wire brake_sw_d = braking_d && pwm_cnt_q < duty_q;

  // Braking state and chopper period counter
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      braking_q <= 1'b0;
      pwm_cnt_q <= 7'h00;
      brake_sw_q <= 1'b0;
    end else begin
      braking_q <= braking_d;
      pwm_cnt_q <= braking_d ? pwm_next : 7'h00;
      brake_sw_q <= brake_sw_d;
    end
  end

  // ---------------------------------------------------------------
  // Fan control
  // ---------------------------------------------------------------
  das_fan_state_t fan_st_q;
  logic [$clog2(PRERUN_CYC + 1)-1:0] pre_cnt_q;
  logic fan_temp_q;
  logic fan_q;
  logic low_spd_en_q;

  wire [1:0] fan_mode = fan_set_q[1:0];
  wire pwr_direct = fan_set_q[4];
  wire low_spd_en = fan_set_q[9:8] == 2'h2;
  wire fan_temp_d = temp_i > FAN_ON_T ? 1'b1 : (temp_i < FAN_OFF_T ? 1'b0 : fan_temp_q);
  wire pre_done = pre_cnt_q == ($bits(pre_cnt_q))'(PRERUN_CYC - 1);
  logic fan_mode_on;

  // Fan demand for the selected mode
  always_comb begin
    unique case (das_fan_mode_t'(fan_mode))
      FAN_POWER: fan_mode_on = 1'b1;
      FAN_START: fan_mode_on = running_i;
      FAN_TEMP: fan_mode_on = fan_temp_d;
      default: fan_mode_on = 1'b1;
    endcase
  end

  // one-minute prerun after power up, or direct mode
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fan_st_q <= FS_PRERUN;
      pre_cnt_q <= '0;
      fan_temp_q <= 1'b0;
      fan_q <= 1'b0;
    end else begin
      fan_temp_q <= fan_temp_d;
      if (fan_st_q == FS_PRERUN && !pwr_direct && !pre_done) begin
        pre_cnt_q <= pre_cnt_q + 1'b1;
        fan_q <= 1'b1;
      end else begin
        fan_st_q <= FS_MODE;
        fan_q <= fan_mode_on;
      end
    end
  end

  // ---------------------------------------------------------------
  // Frequency, modulation and jog
  // ---------------------------------------------------------------
  logic shut_q;
  logic [15:0] fcmd_q;
  logic five_q;
  logic jog_q;

  wire below = set_freq_i < low_freq_q;
  wire five_d = mod_sw_q && out_freq_i > mod_freq_q;
  // direct jog only under terminal control with priority
  wire jog_d = cmd_src_q == SRC_TERMINAL && jog_pri_q && jog_term_i;

  // Operating selections
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shut_q <= 1'b0;
      fcmd_q <= 16'h0000;
      five_q <= 1'b0;
      jog_q <= 1'b0;
    end else begin
      shut_q <= below && below_act_q;
      fcmd_q <= below ? (below_act_q ? 16'h0000 : low_freq_q) : set_freq_i;
      five_q <= five_d;
      jog_q <= jog_d;
    end
  end

  // ---------------------------------------------------------------
  // Current and torque reached
  // ---------------------------------------------------------------
  logic cur_q;
  logic trq_q;

  // set while running and strictly above
  wire cur_set = running_i && out_cur_i > cur_thr_q;
  // clear at or below threshold minus hysteresis, in any state
  wire cur_clr = {1'b0, out_cur_i} + {1'b0, cur_hys_q} <= {1'b0, cur_thr_q};
  wire trq_set = running_i && out_trq_i > trq_thr_q;
  wire trq_clr = {1'b0, out_trq_i} + {1'b0, trq_hys_q} <= {1'b0, trq_thr_q};

  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cur_q <= 1'b0;
      trq_q <= 1'b0;
    end else begin
      cur_q <= cur_set ? 1'b1 : (cur_clr ? 1'b0 : cur_q);
      trq_q <= trq_set ? 1'b1 : (trq_clr ? 1'b0 : trq_q);
    end
  end

  // ---------------------------------------------------------------
  // Read back
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  // Unmapped addresses read as zero
  always_comb begin
    unique case (addr_i)
      A_BRAKE_CTRL: rd_mux = {17'h0, duty_q, 7'h0, brake_en_q};
      A_BRAKE_VOLT: rd_mux = {16'h0, bvolt_q};
      A_FREQ_CTRL: rd_mux = {31'h0, below_act_q};
      A_LOW_FREQ: rd_mux = {16'h0, low_freq_q};
      A_FAN_CTRL: rd_mux = {22'h0, fan_set_q};
      A_OVERMOD: rd_mux = {25'h0, ovm_q};
      A_MOD_CTRL: rd_mux = {26'h0, dz_q, 3'h0, mod_sw_q};
      A_MOD_FREQ: rd_mux = {16'h0, mod_freq_q};
      A_JOG_CTRL: rd_mux = {29'h0, cmd_src_q, jog_pri_q};
      A_RSTOP: rd_mux = {16'h0, rstop_q};
      A_CUR_THR: rd_mux = {cur_hys_q, cur_thr_q};
      A_TRQ_THR: rd_mux = {trq_hys_q, trq_thr_q};
      A_STATUS: rd_mux = {24'h0, jog_q, five_q, shut_q, trq_q, cur_q, fan_q,
                          brake_sw_q, braking_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdata_o = rdata_q;
  assign brake_sw_o = brake_sw_q;
  assign fan_on_o = fan_q;
  assign fan_low_speed_o = low_spd_en_q;
  assign shutdown_o = shut_q;
  assign freq_cmd_o = fcmd_q;
  assign five_seg_o = five_q;
  assign dead_zone_o = dz_q;
  // ceiling scale in 0.01 units, max 1.10
  assign overmod_o = ovm_q;
  assign jog_select_o = jog_q;
  assign ramp_time_o = rstop_q;
  assign cur_reached_o = cur_q;
  assign trq_reached_o = trq_q;

  // Low-speed enable registered for a flop-driven output
  always_ff @(posedge mclk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      low_spd_en_q <= 1'b0;
    end else begin
      low_spd_en_q <= low_spd_en;
    end
  end

endmodule

// *** dv/das_chk_sva.sv ***
// Port-level assertion checker for the drive auxiliary supervisor
module das_chk_sva
  import das_pkg::*;
(
  // Clock, reset and register port
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  // Measurements and status
  input wire logic [15:0] out_cur_i,
  input wire logic [15:0] out_trq_i,
  input wire logic running_i,
  input wire logic jog_term_i,
  // Watched outputs
  input wire logic brake_sw_o,
  input wire logic shutdown_o,
  input wire logic [15:0] freq_cmd_o,
  input wire logic five_seg_o,
  input wire logic [1:0] dead_zone_o,
  input wire logic [6:0] overmod_o,
  input wire logic jog_select_o,
  input wire logic [15:0] ramp_time_o,
  input wire logic cur_reached_o,
  input wire logic trq_reached_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Settings mirror
  // ---------------------------------------------------------------
  logic [1:0] sync_q;
  logic [31:0] cur_q;
  logic [31:0] trq_q;
  logic [2:0] jog_q;
  logic msw_q;
  logic cur_ok, trq_ok, cset, cclr, tset, tclr;
  // Out-of-range threshold writes are dropped, so the mirror drops them too
  assign cur_ok = wdata_i[15:0] <= PCT_MAX && wdata_i[31:16] <= wdata_i[15:0];
  assign trq_ok = cur_ok;
  assign cset = running_i && out_cur_i > cur_q[15:0];
  assign cclr = {1'b0, out_cur_i} + cur_q[31:16] <= {1'b0, cur_q[15:0]};
  assign tset = running_i && out_trq_i > trq_q[15:0];
  assign tclr = {1'b0, out_trq_i} + trq_q[31:16] <= {1'b0, trq_q[15:0]};
  // Own two-flop release keeps properties quiet while the design is held
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_q <= 2'h0;
      cur_q <= {HYST_DEF, THR_DEF};
      trq_q <= {HYST_DEF, THR_DEF};
      jog_q <= 3'h0;
      msw_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], 1'b1};
      if (wr_i && addr_i == A_CUR_THR && cur_ok) cur_q <= wdata_i;
      if (wr_i && addr_i == A_TRQ_THR && trq_ok) trq_q <= wdata_i;
      if (wr_i && addr_i == A_JOG_CTRL) jog_q <= wdata_i[2:0];
      if (wr_i && addr_i == A_MOD_CTRL) msw_q <= wdata_i[0];
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!sync_q[1]);
  rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero outside read");
  unmapped_a: assert property (rd_i && addr_i > A_STATUS |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  cur_set_a: assert property (cset |=> cur_reached_o)
    else $error("current flag not set");
  cur_clear_a: assert property (cclr |=> !cur_reached_o)
    else $error("current flag not cleared");
  cur_hold_a: assert property (!cset && !cclr |=> $stable(cur_reached_o))
    else $error("current flag moved in band");
  trq_set_a: assert property (tset |=> trq_reached_o)
    else $error("torque flag not set");
  trq_hold_a: assert property (!tset && !tclr |=> $stable(trq_reached_o))
    else $error("torque flag moved in band");
  trq_clear_a: assert property (tclr |=> !trq_reached_o)
    else $error("torque flag not cleared");
  jog_direct_a: assert property (jog_q == 3'h3 && jog_term_i |=> jog_select_o)
    else $error("direct jog missing");
  jog_block_a: assert property (!jog_q[0] |=> !jog_select_o)
    else $error("jog taken without priority");
  seven_fixed_a: assert property (!msw_q |=> !five_seg_o)
    else $error("five segment with switching off");
  ovm_range_a: assert property (overmod_o >= OVM_MIN && overmod_o <= OVM_MAX)
    else $error("overmodulation out of range");
  dz_range_a: assert property (dead_zone_o != 2'h3)
    else $error("dead zone mode invalid");
  ramp_max_a: assert property (ramp_time_o <= RSTOP_MAX)
    else $error("ramp time out of range");
  shut_zero_a: assert property (shutdown_o |-> freq_cmd_o == 16'h0)
    else $error("frequency command during shutdown");
  cover property ($rose(cur_reached_o));
  cover property ($rose(brake_sw_o));
  cover property ($rose(jog_select_o));
  cover property ($rose(five_seg_o));
endmodule

// *** dv/das_stage_model.sv ***
// Power stage model: counts chopper on-cycles inside a gated window
module das_stage_model (
  // Clock and window gate
  input wire logic mclk_i,
  input wire logic en_i,
  // Chopper gate from the supervisor
  input wire logic brake_sw_i,
  // On-cycles seen in the window
  output logic [7:0] on_cnt_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // Cleared whenever the window is closed, so each window starts clean
  always_ff @(posedge mclk_i) begin
    if (!en_i) begin
      on_cnt_o <= 8'h00;
    end else if (brake_sw_i) begin
      on_cnt_o <= on_cnt_o + 8'h01;
    end
  end
endmodule

// *** dv/test_drive_auxiliary_supervisor.sv ***
// Self-checking testbench for the drive auxiliary supervisor
module test_drive_auxiliary_supervisor
  import das_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic mclk_i, rst_b_i, wr_i, rd_i, running_i, jog_term_i, en;
  logic [7:0] addr_i, on_cnt;
  logic [31:0] wdata_i, rdata_o, rv;
  logic [15:0] bus_volt_i, temp_i, out_cur_i, out_trq_i, out_freq_i, set_freq_i;
  logic brake_sw_o, fan_on_o, fan_low_speed_o, shutdown_o, five_seg_o, jog_select_o;
  logic cur_reached_o, trq_reached_o;
  logic [15:0] freq_cmd_o, ramp_time_o;
  logic [1:0] dead_zone_o;
  logic [6:0] overmod_o;
  int err_count, n_tests;
  // Short prerun keeps the power-on fan phase inside the run
  das_top #(.PRERUN_CYC(20)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .bus_volt_i(bus_volt_i), .temp_i(temp_i), .out_cur_i(out_cur_i),
    .out_trq_i(out_trq_i), .out_freq_i(out_freq_i), .set_freq_i(set_freq_i),
    .running_i(running_i), .jog_term_i(jog_term_i), .brake_sw_o(brake_sw_o),
    .fan_on_o(fan_on_o), .fan_low_speed_o(fan_low_speed_o), .shutdown_o(shutdown_o),
    .freq_cmd_o(freq_cmd_o), .five_seg_o(five_seg_o), .dead_zone_o(dead_zone_o),
    .overmod_o(overmod_o), .jog_select_o(jog_select_o), .ramp_time_o(ramp_time_o),
    .cur_reached_o(cur_reached_o), .trq_reached_o(trq_reached_o));
  das_stage_model stg_u (.mclk_i(mclk_i), .en_i(en), .brake_sw_i(brake_sw_o),
    .on_cnt_o(on_cnt));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task at();
    @(posedge mclk_i);
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    at();
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    at();
    wr_i <= 1'b0;
  endtask
  // Read data is taken in the cycle right after the strobe edge
  task rd(input logic [7:0] a);
    at();
    addr_i <= a;
    rd_i <= 1'b1;
    at();
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  // Any 100 consecutive cycles span one full chopper period
  task win(input logic [7:0] e, input string m);
    at();
    en <= 1'b1;
    repeat (100) at();
    en <= 1'b0;
    #1 chk({24'h0, on_cnt}, {24'h0, e}, m);
  endtask
  task test_done();
    $display("errors %0d checks %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_reset();
    chk({dead_zone_o, overmod_o, ramp_time_o}, {DZ_DEF, OVM_DEF, RSTOP_DEF}, "resets");
    chk(fan_on_o, 1'b1, "prerun fan");
    rd(A_CUR_THR);
    chk(rv, {HYST_DEF, THR_DEF}, "cur thr reset");
    rd(A_TRQ_THR);
    chk(rv, {HYST_DEF, THR_DEF}, "trq thr reset");
    rd(8'h40);
    chk(rv, 32'h0, "unmapped read");
    rd(A_FAN_CTRL);
    chk(rv, 32'h101, "fan default");
    wt(30);
    chk(fan_on_o, 1'b0, "prerun over");
  endtask
  task automatic t_fan();
    logic [15:0] tv [5] = '{16'h01CC, 16'h0190, 16'h018F, 16'h01C2, 16'h01C3};
    logic [4:0] ev = 5'b10011;
    wr(A_FAN_CTRL, 32'h112);
    for (int i = 0; i < 5; i++) begin
      at();
      temp_i <= tv[i];
      wt(3);
      chk(fan_on_o, ev[i], "fan band");
    end
    wr(A_FAN_CTRL, 32'h212);
    wt(2);
    chk(fan_low_speed_o, 1'b1, "low speed on");
    wr(A_FAN_CTRL, 32'h111);
    wt(2);
    chk(fan_on_o, 1'b0, "fan idle stop");
    // Bad ones digit must leave mode 1 in place, so the fan stays off
    wr(A_FAN_CTRL, 32'h113);
    wt(2);
    chk(fan_on_o, 1'b0, "bad digit kept");
    at();
    running_i <= 1'b1;
    wt(2);
    chk(fan_on_o, 1'b1, "fan at start");
    at();
    running_i <= 1'b0;
    wr(A_FAN_CTRL, 32'h110);
    wt(2);
    chk({fan_on_o, fan_low_speed_o}, 2'b10, "fan on power");
  endtask
  task t_brake();
    at();
    bus_volt_i <= 16'h0514;
    wr(A_BRAKE_CTRL, 32'h1400);
    win(8'h00, "brake disabled");
    wr(A_BRAKE_CTRL, 32'h1401);
    win(8'h14, "duty 20");
    wr(A_BRAKE_CTRL, 32'h1301);
    win(8'h14, "duty 19 refused");
    wr(A_BRAKE_CTRL, 32'h6401);
    win(8'h64, "duty 100");
    rd(A_STATUS);
    chk(rv[0], 1'b1, "status braking");
    at();
    bus_volt_i <= BVOLT_DEF;
    win(8'h64, "equal holds");
    at();
    bus_volt_i <= 16'h04E1;
    win(8'h00, "brake stops");
  endtask
  task t_limit();
    wr(A_LOW_FREQ, 32'h3E8);
    at();
    set_freq_i <= 16'h01F4;
    wt(2);
    chk({shutdown_o, freq_cmd_o}, {1'b0, 16'h03E8}, "run at limit");
    wr(A_FREQ_CTRL, 32'h1);
    wt(2);
    chk({shutdown_o, freq_cmd_o}, {1'b1, 16'h0000}, "shut down");
    at();
    set_freq_i <= 16'h04B0;
    wt(2);
    chk({shutdown_o, freq_cmd_o}, {1'b0, 16'h04B0}, "above limit");
  endtask
  task t_mod();
    at();
    out_freq_i <= 16'h0640;
    wt(2);
    chk(five_seg_o, 1'b0, "seven fixed");
    wr(A_MOD_CTRL, 32'h21);
    wt(2);
    chk({dead_zone_o, five_seg_o}, 3'b101, "five above");
    at();
    out_freq_i <= 16'h0578;
    wt(2);
    chk(five_seg_o, 1'b0, "seven below");
    wr(A_MOD_CTRL, 32'h31);
    wt(2);
    chk(dead_zone_o, 2'h2, "dead zone 3 refused");
    wr(A_MOD_CTRL, 32'h0);
    wt(2);
    chk(dead_zone_o, 2'h0, "no compensation");
    wr(A_OVERMOD, 32'h6E);
    wr(A_OVERMOD, 32'h6F);
    wr(A_OVERMOD, 32'h63);
    wt(2);
    chk(overmod_o, OVM_MAX, "overmod limits");
    wr(A_RSTOP, 32'hFDE9);
    wt(2);
    chk(ramp_time_o, RSTOP_DEF, "ramp refused");
    wr(A_RSTOP, 32'hFDE8);
    wt(2);
    chk(ramp_time_o, RSTOP_MAX, "ramp max");
  endtask
  task automatic t_jog();
    logic [31:0] jv [3] = '{32'h3, 32'h2, 32'h1};
    at();
    jog_term_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(A_JOG_CTRL, jv[i]);
      wt(2);
      chk(jog_select_o, i == 0, "jog select");
    end
  endtask
  task automatic t_reach();
    logic [15:0] cv [8] = '{16'h03E8, 16'h03E9, 16'h03B7, 16'h03B6,
                           16'h044C, 16'h044C, 16'h03B7, 16'h03B6};
    logic [15:0] tq [8] = '{16'h07D0, 16'h07D1, 16'h076D, 16'h076C,
                           16'h0834, 16'h0834, 16'h076D, 16'h076C};
    logic [7:0] rn = 8'b0010_1111;
    logic [7:0] ex = 8'b0110_0110;
    wr(A_CUR_THR, 32'h00320BB9);
    rd(A_CUR_THR);
    chk(rv, {HYST_DEF, THR_DEF}, "thr 3001 refused");
    wr(A_TRQ_THR, 32'h006407D0);
    rd(A_TRQ_THR);
    chk(rv, 32'h006407D0, "trq thr set");
    for (int i = 0; i < 8; i++) begin
      at();
      running_i <= rn[i];
      out_cur_i <= cv[i];
      out_trq_i <= tq[i];
      wt(2);
      chk({cur_reached_o, trq_reached_o}, {ex[i], ex[i]}, "reach flags");
    end
  endtask

  // ---------------------------------------------------------------
  // Clock, main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  initial begin
    {rst_b_i, wr_i, rd_i, running_i, jog_term_i, en} = 6'h0;
    {addr_i, wdata_i} = 40'h0;
    {bus_volt_i, temp_i, out_cur_i, out_trq_i, out_freq_i, set_freq_i} = 96'h0;
    err_count = 0;
    n_tests = 0;
    repeat (10) at();
    rst_b_i <= 1'b1;
    wt(4);
    t_reset();
    t_fan();
    t_brake();
    t_limit();
    t_mod();
    t_jog();
    t_reach();
    test_done();
  end
  // Whole run needs about 800 cycles; allow over forty times that
  initial begin
    #2000000;
    err_count++;
    test_done();
  end
endmodule

bind das_top das_chk_sva chk_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .out_cur_i(out_cur_i),
  .out_trq_i(out_trq_i), .running_i(running_i), .jog_term_i(jog_term_i),
  .brake_sw_o(brake_sw_o), .shutdown_o(shutdown_o), .freq_cmd_o(freq_cmd_o),
  .five_seg_o(five_seg_o), .dead_zone_o(dead_zone_o), .overmod_o(overmod_o),
  .jog_select_o(jog_select_o), .ramp_time_o(ramp_time_o),
  .cur_reached_o(cur_reached_o), .trq_reached_o(trq_reached_o));
